// ==== src/power_mode_controller.sv ====
// power mode sequencer with clock select, divider and wake logic
// What this block does
// [R01] normal mode: core clocked, peripherals clocked where their gate register bit is set, no wake source used
// [R02] idle request halts core only; any interrupt wakes it
// [R03] firmware selects 24.5 MHz source before setting suspend request
// [R04] firmware selects 24.5 MHz source before setting snooze request
// [R05] suspend and snooze stop core, peripheral clocks and both fast oscillators
// [R06] suspend keeps regulators in normal bias
// [R07] snooze puts regulators in low bias
// [R08] timers three and four may run from slow oscillator in suspend, snooze
// [R09] usb, timer four, spi, port match, comparator fall, logic unit wake
// [R10] stop entry: clear deep-shutdown select, then set stop request
// [R11] stop: power nets off, 1.8 V regulator on, pins held, reset exits
// [R12] shutdown entry: set deep-shutdown select, then set stop request
// [R13] shutdown: low-voltage regulator off, pins held, pin or power-on reset exits
// [R14] after reset system clock is 24.5 MHz source divided by 8
// [R15] divider offers divide by 1, 2, 4, 8, 16, 32, 64, 128
// [R16] unused digital peripherals have their clocks gated off
// [R17] low-power request bits clear themselves on wake
`timescale 1ns/1ps
module power_mode_controller
  import pmc_pkg::*;
#(
  parameter int NumPeriphClk = NumPeriph
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [AddrWidth-1:0] regAddr,
  input wire logic [DataWidth-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DataWidth-1:0] regRdata,
  input wire logic anyIrq,
  input wire logic usbActivity,
  input wire logic timer4Event,
  input wire logic spiActivity,
  input wire logic portMatch,
  input wire logic comparator0Out,
  input wire logic configLogicUnitEvent,
  input wire logic configLogicUnitIrqEn,
  output logic coreClkEn,
  output logic [NumPeriphClk-1:0] periphClkEn,
  output logic sysClkTick,
  output logic [1:0] systemClockSelect,
  output logic fastOsc24mEn,
  output logic fastOsc48mEn,
  output logic slowOsc80kEn,
  output logic timer34SlowClkEn,
  output logic regLowBias,
  output logic ldoEn,
  output logic powerNetsEn,
  output logic pinHold,
  output logic irq
);
  logic [1:0] powerCtrlRegA_q;
  logic [1:0] powerCtrlRegB_q;
  logic deepShutdownSelect_q;
  logic [7:0] clkSel_q;
  logic [7:0] gate_q;
  logic [1:0] irqStat_q;
  logic [1:0] irqMask_q;
  mode_type mode_q;
  mode_type mode_d;
  logic [NumWake-1:0] wakeEvt;
  logic [NumWake-1:0] wakeSrc;
  logic [NumWake-1:0] wakeEn;
  logic lowPowerWake;
  logic idleWake;
  logic wrA;
  logic wrB;
  logic divTick;
  logic divRun;

  assign wrA = regWrite && (regAddr == OffCtrlA);
  assign wrB = regWrite && (regAddr == OffCtrlB);

  // wake sources for suspend and snooze
  assign wakeSrc = {configLogicUnitEvent, comparator0Out, portMatch,
                    spiActivity, timer4Event, usbActivity};
  assign wakeEn = {configLogicUnitIrqEn, {(NumWake-1){1'b1}}};

  genvar gi;
  generate
    for (gi = 0; gi < NumWake; gi++)
    begin : g_wake
      wake_detect #(
        .FallEdge(gi == 4)
      ) u_wake (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .source(wakeSrc[gi]),
        .enable(wakeEn[gi]),
        .event_o(wakeEvt[gi])
      );
    end
  endgenerate

  assign lowPowerWake = |wakeEvt; // [R09]
  assign idleWake = anyIrq; // [R02]

  // mode sequencing
  always_comb
  begin
    mode_d = mode_q;
    unique case (mode_q)
      ModeNormal:
      begin
        if (powerCtrlRegA_q[BitStop])
          mode_d = deepShutdownSelect_q ? ModeShutdown : ModeStop; // [R10] [R12]
        else if (powerCtrlRegB_q[BitSnooze])
          mode_d = ModeSnooze; // [R04]
        else if (powerCtrlRegB_q[BitSuspend])
          mode_d = ModeSuspend; // [R03]
        else if (powerCtrlRegA_q[BitIdle])
          mode_d = ModeIdle;
      end
      ModeIdle:
        if (idleWake)
          mode_d = ModeNormal; // [R02]
      ModeSuspend, ModeSnooze:
        if (lowPowerWake)
          mode_d = ModeNormal; // [R05]
      // only a reset leaves these
      ModeStop: mode_d = ModeStop; // [R11]
      ModeShutdown: mode_d = ModeShutdown; // [R13]
      default: mode_d = ModeNormal;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_q <= ModeNormal;
    else
      mode_q <= mode_d;
  end

  // request bits, cleared by hardware on wake
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      powerCtrlRegA_q <= 2'h0;
      powerCtrlRegB_q <= 2'h0;
    end
    else
    begin
      if (mode_q != ModeNormal && mode_d == ModeNormal)
      begin
        powerCtrlRegA_q <= 2'h0; // [R17]
        powerCtrlRegB_q <= 2'h0; // [R17]
      end
      else
      begin
        if (wrA)
          powerCtrlRegA_q <= powerCtrlRegA_q | regWdata[1:0];
        if (wrB)
          powerCtrlRegB_q <= powerCtrlRegB_q | regWdata[1:0];
      end
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      deepShutdownSelect_q <= 1'b0;
      clkSel_q <= ClkSelReset; // [R14]
      gate_q <= GateReset;
      irqMask_q <= 2'h0;
    end
    else if (regWrite)
    begin
      if (regAddr == OffRegCtl)
        deepShutdownSelect_q <= regWdata[BitDeepSel];
      if (regAddr == OffClkSel)
        clkSel_q <= {3'h0, regWdata[4:0]}; // [R15]
      if (regAddr == OffGate)
        gate_q <= regWdata;
      if (regAddr == OffIrqMask)
        irqMask_q <= regWdata[1:0];
    end
  end

  // sticky interrupt status, set beats clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      irqStat_q <= 2'h0;
    else
    begin
      logic [1:0] setBits;
      logic [1:0] clrBits;
      setBits = 2'h0;
      clrBits = 2'h0;
      setBits[IrqWake] = (mode_q == ModeSuspend || mode_q == ModeSnooze) && lowPowerWake;
      setBits[IrqIdleExit] = (mode_q == ModeIdle) && idleWake;
      if (regWrite && regAddr == OffIrqStat)
        clrBits = regWdata[1:0];
      irqStat_q <= (irqStat_q & ~clrBits) | setBits;
    end
  end

  // register read, one cycle later
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= 8'h00;
    else if (regRead)
    begin
      unique case (regAddr)
        OffCtrlA: regRdata <= {6'h00, powerCtrlRegA_q};
        OffCtrlB: regRdata <= {6'h00, powerCtrlRegB_q};
        OffRegCtl: regRdata <= {7'h00, deepShutdownSelect_q};
        OffClkSel: regRdata <= clkSel_q;
        OffGate: regRdata <= gate_q;
        OffStatus: regRdata <= {5'h00, mode_q};
        OffIrqStat: regRdata <= {6'h00, irqStat_q};
        OffIrqMask: regRdata <= {6'h00, irqMask_q};
        default: regRdata <= 8'h00;
      endcase
    end
    else
      regRdata <= 8'h00;
  end

  assign divRun = (mode_q == ModeNormal) || (mode_q == ModeIdle);

  clock_divider u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(divRun),
    .divCode(clkSel_q[2:0]), // [R15]
    .tick(divTick)
  );

  // registered power and clock outputs
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      coreClkEn <= 1'b1;
      periphClkEn <= '1;
      sysClkTick <= 1'b0;
      systemClockSelect <= SrcFast24; // [R14]
      fastOsc24mEn <= 1'b1;
      fastOsc48mEn <= 1'b0;
      slowOsc80kEn <= 1'b1;
      timer34SlowClkEn <= 1'b0;
      regLowBias <= 1'b0;
      ldoEn <= 1'b1;
      powerNetsEn <= 1'b1;
      pinHold <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      coreClkEn <= (mode_d == ModeNormal); // [R01] [R02]
      periphClkEn <= (mode_d == ModeNormal || mode_d == ModeIdle)
                     ? gate_q[NumPeriphClk-1:0] : '0; // [R16] [R05]
      sysClkTick <= divTick;
      systemClockSelect <= clkSel_q[BitSrc +: 2];
      fastOsc24mEn <= (mode_d == ModeNormal || mode_d == ModeIdle)
                      && clkSel_q[BitSrc +: 2] == SrcFast24; // [R05]
      fastOsc48mEn <= (mode_d == ModeNormal || mode_d == ModeIdle)
                      && clkSel_q[BitSrc +: 2] == SrcFast48; // [R05]
      slowOsc80kEn <= (mode_d != ModeStop) && (mode_d != ModeShutdown);
      timer34SlowClkEn <= (mode_d == ModeSuspend || mode_d == ModeSnooze); // [R08]
      regLowBias <= (mode_d == ModeSnooze); // [R06] [R07]
      ldoEn <= (mode_d != ModeShutdown); // [R11] [R13]
      powerNetsEn <= (mode_d != ModeStop) && (mode_d != ModeShutdown); // [R11]
      pinHold <= (mode_d == ModeStop) || (mode_d == ModeShutdown); // [R11] [R13]
      irq <= |(irqStat_q & irqMask_q);
    end
  end
endmodule

// ==== src/pmc_pkg.sv ====
// shared constants for the power mode controller
package pmc_pkg;
  localparam int AddrWidth = 4;
  localparam int DataWidth = 8;
  // register offsets
  localparam logic [3:0] OffCtrlA = 4'h0;
  localparam logic [3:0] OffCtrlB = 4'h1;
  localparam logic [3:0] OffRegCtl = 4'h2;
  localparam logic [3:0] OffClkSel = 4'h3;
  localparam logic [3:0] OffGate = 4'h4;
  localparam logic [3:0] OffStatus = 4'h5;
  localparam logic [3:0] OffIrqStat = 4'h6;
  localparam logic [3:0] OffIrqMask = 4'h7;
  // field positions
  localparam int BitIdle = 0;
  localparam int BitStop = 1;
  localparam int BitSuspend = 0;
  localparam int BitSnooze = 1;
  localparam int BitDeepSel = 0;
  localparam int BitSrc = 3;
  // clock select: divider code in [2:0], source in [4:3]
  localparam logic [1:0] SrcFast24 = 2'h0;
  localparam logic [1:0] SrcFast48 = 2'h1;
  localparam logic [1:0] SrcSlow80 = 2'h2;
  localparam logic [2:0] DivReset = 3'h3;
  localparam logic [7:0] ClkSelReset = 8'h03;
  localparam logic [7:0] GateReset = 8'hff;
  localparam int NumWake = 6;
  localparam int NumPeriph = 8;
  // interrupt status bits
  localparam int IrqWake = 0;
  localparam int IrqIdleExit = 1;
  typedef enum logic [2:0] {
    ModeNormal = 3'b000,
    ModeIdle = 3'b001,
    ModeSuspend = 3'b011,
    ModeSnooze = 3'b010,
    ModeStop = 3'b110,
    ModeShutdown = 3'b111
  } mode_type;
endpackage

// ==== src/clock_divider.sv ====
// power-of-two clock enable divider, 1 to 128
`timescale 1ns/1ps
module clock_divider
  import pmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] divCode,
  output logic tick
);
  logic [6:0] count_q;
  logic [6:0] limit;
  assign limit = 7'((8'h01 << divCode) - 8'h01);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= 7'h00;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      count_q <= 7'h00;
      tick <= 1'b0;
    end
    else if (count_q >= limit)
    begin
      count_q <= 7'h00;
      tick <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule

// ==== src/wake_detect.sv ====
// qualified wake event detector, falling-edge aware
`timescale 1ns/1ps
module wake_detect
  import pmc_pkg::*;
#(
  parameter bit FallEdge = 1'b0
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic source,
  input wire logic enable,
  output logic event_o
);
  logic prev_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q <= 1'b0;
      event_o <= 1'b0;
    end
    else
    begin
      prev_q <= source;
      event_o <= enable & (FallEdge ? (prev_q & ~source) : source);
    end
  end
endmodule

// ==== testbench/power_mode_controller_props.sv ====
// port checker for the power mode controller
`timescale 1ns/1ps
module power_mode_controller_props
  import pmc_pkg::*;
#(
  parameter int NumPeriphClk = NumPeriph
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [AddrWidth-1:0] regAddr,
  input wire logic [DataWidth-1:0] regWdata,
  input wire logic regWrite,
  input wire logic anyIrq,
  input wire logic usbActivity,
  input wire logic coreClkEn,
  input wire logic [NumPeriphClk-1:0] periphClkEn,
  input wire logic fastOsc24mEn,
  input wire logic fastOsc48mEn,
  input wire logic timer34SlowClkEn,
  input wire logic regLowBias,
  input wire logic ldoEn,
  input wire logic powerNetsEn,
  input wire logic pinHold
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_lp_clocks;
    timer34SlowClkEn |-> !coreClkEn && periphClkEn == 0 && !fastOsc24mEn && !fastOsc48mEn;
  endproperty
  a_lp_clocks: assert property (p_lp_clocks) else $error("clock on in low power");
  property p_bias; regLowBias |-> timer34SlowClkEn && ldoEn && powerNetsEn; endproperty
  a_bias: assert property (p_bias) else $error("low bias outside snooze");
  property p_stop; pinHold |-> !powerNetsEn && !coreClkEn && !timer34SlowClkEn; endproperty
  a_stop: assert property (p_stop) else $error("power nets on while pins held");
  property p_ldo_off; !ldoEn |-> pinHold && !powerNetsEn; endproperty
  a_ldo_off: assert property (p_ldo_off) else $error("regulator off outside shutdown");
  property p_stop_stays; pinHold |=> pinHold; endproperty
  a_stop_stays: assert property (p_stop_stays) else $error("stop left without reset");
  // request lands at the write edge, outputs follow one edge later
  property p_idle_in;
    regWrite && regAddr == OffCtrlA && regWdata == 8'h01 && coreClkEn
      |-> ##2 !coreClkEn && !timer34SlowClkEn && !pinHold;
  endproperty
  a_idle_in: assert property (p_idle_in) else $error("idle request not taken");
  property p_idle_out;
    !coreClkEn && !timer34SlowClkEn && !pinHold && anyIrq |=> coreClkEn;
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("interrupt did not end idle");
  property p_lp_wake; timer34SlowClkEn && usbActivity |-> ##2 coreClkEn; endproperty
  a_lp_wake: assert property (p_lp_wake) else $error("bus activity did not wake");
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module tb
  import pmc_pkg::*;
;
  typedef struct packed {logic [3:0] a; logic [7:0] v;} row_type;
  row_type rows[7] = '{'{OffCtrlA, 8'h00}, '{OffCtrlB, 8'h00}, '{OffRegCtl, 8'h00},
    '{OffClkSel, ClkSelReset}, '{OffGate, GateReset}, '{OffStatus, 8'h00}, '{4'hc, 8'h00}};
  logic ref_clk = 0, rst_n = 0, regWrite = 0, regRead = 0, anyIrq = 0, cluEn = 1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata, periphClkEn, d;
  logic [5:0] wk = 6'h00;
  logic coreClkEn, sysClkTick, fastOsc24mEn, fastOsc48mEn, slowOsc80kEn, timer34SlowClkEn;
  logic regLowBias, ldoEn, powerNetsEn, pinHold, irq;
  logic [1:0] systemClockSelect;
  int fails = 0, checks = 0, cyc = 0, n;
  power_mode_controller i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .anyIrq(anyIrq), .usbActivity(wk[0]), .timer4Event(wk[1]), .spiActivity(wk[2]),
    .portMatch(wk[3]), .comparator0Out(~wk[4]), .configLogicUnitEvent(wk[5]),
    .configLogicUnitIrqEn(cluEn), .coreClkEn(coreClkEn), .periphClkEn(periphClkEn),
    .sysClkTick(sysClkTick), .systemClockSelect(systemClockSelect),
    .fastOsc24mEn(fastOsc24mEn), .fastOsc48mEn(fastOsc48mEn), .slowOsc80kEn(slowOsc80kEn),
    .timer34SlowClkEn(timer34SlowClkEn), .regLowBias(regLowBias), .ldoEn(ldoEn),
    .powerNetsEn(powerNetsEn), .pinHold(pinHold), .irq(irq));
  always #50 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk) {regWrite, regAddr, regWdata} <= {1'b1, a, v};
    @(posedge ref_clk) regWrite <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk) {regRead, regAddr} <= {1'b1, a};
    @(posedge ref_clk) regRead <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic pulse(input logic [5:0] w, input logic i);
    @(posedge ref_clk) {wk, anyIrq} <= {w, i};
    @(posedge ref_clk) {wk, anyIrq} <= 7'h00;
  endtask
  task automatic rst();
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    rst();
    chk("source", 8'h00, {6'h0, systemClockSelect});
    foreach (rows[i])
    begin
      rd(rows[i].a, d);
      chk("reset value", rows[i].v, d);
    end
    $display("test reset finished");
    for (int c = 0; c < 8; c++)
    begin
      wr(OffClkSel, 8'(c));
      repeat (128) @(posedge ref_clk);
      n = 0;
      repeat (128) @(posedge ref_clk) #1 n += int'(sysClkTick);
      chk("ticks", 8'h80 >> c, 8'(n));
    end
    wr(OffClkSel, 8'h0b);
    @(posedge ref_clk) #1 chk("source 48m", 8'h05,
      {4'h0, systemClockSelect, fastOsc24mEn, fastOsc48mEn});
    wr(OffClkSel, 8'h03);
    $display("test divider finished");
    wr(OffGate, 8'h5a);
    @(posedge ref_clk) #1 chk("gate", 8'h5a, periphClkEn);
    wr(OffCtrlA, 8'h01);
    @(posedge ref_clk) #1 chk("idle", 8'h5a, {periphClkEn[7:1], coreClkEn});
    pulse(6'h00, 1'b1);
    #1 chk("idle wake", 8'h01, {7'h0, coreClkEn});
    $display("test idle finished");
    for (int m = 0; m < 2; m++)
      for (int s = 0; s < 6; s++)
      begin
        wr(OffCtrlB, 8'h01 << m);
        @(posedge ref_clk) #1 chk("lowpower", 8'he2 | 8'(m),
          {slowOsc80kEn, ldoEn, powerNetsEn, coreClkEn, |periphClkEn, fastOsc24mEn,
          timer34SlowClkEn,
          regLowBias});
        rd(OffStatus, d);
        chk("mode", m ? 8'h02 : 8'h03, d);
        pulse(6'h01 << s, 1'b0);
        repeat (2) @(posedge ref_clk);
        #1 chk("wake", 8'h01, {7'h0, coreClkEn});
        rd(OffCtrlB, d);
        chk("request", 8'h00, d);
      end
    chk("masked irq", 8'h00, {7'h0, irq});
    wr(OffIrqMask, 8'h01);
    @(posedge ref_clk) #1 chk("irq", 8'h01, {7'h0, irq});
    wr(OffIrqStat, 8'h01);
    @(posedge ref_clk) #1 chk("irq clear", 8'h00, {7'h0, irq});
    rd(OffIrqStat, d);
    chk("irq status", 8'h02, d);
    @(posedge ref_clk) cluEn <= 1'b0;
    wr(OffCtrlB, 8'h01);
    pulse(6'h20, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1 chk("disabled logic wake", 8'h00, {7'h0, coreClkEn});
    pulse(6'h01, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1 chk("wake after disabled", 8'h01, {7'h0, coreClkEn});
    $display("test wake finished");
    wr(OffRegCtl, 8'h00);
    wr(OffCtrlA, 8'h02);
    pulse(6'h01, 1'b1);
    #1 chk("stop", 8'h0a, {3'h0, slowOsc80kEn, ldoEn, powerNetsEn, pinHold, coreClkEn});
    rst();
    wr(OffRegCtl, 8'h01);
    wr(OffCtrlA, 8'h02);
    @(posedge ref_clk) #1 chk("shutdown", 8'h02,
      {3'h0, slowOsc80kEn, ldoEn, powerNetsEn, pinHold, coreClkEn});
    rst();
    chk("normal", 8'h1d,
      {3'h0, slowOsc80kEn, ldoEn, powerNetsEn, pinHold, coreClkEn});
    $display("test stop finished");
    end_of_test();
  end
endmodule
bind power_mode_controller power_mode_controller_props #(.NumPeriphClk(NumPeriphClk)) i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .anyIrq(anyIrq), .usbActivity(usbActivity), .coreClkEn(coreClkEn),
  .periphClkEn(periphClkEn), .fastOsc24mEn(fastOsc24mEn), .fastOsc48mEn(fastOsc48mEn),
  .timer34SlowClkEn(timer34SlowClkEn), .regLowBias(regLowBias), .ldoEn(ldoEn),
  .powerNetsEn(powerNetsEn), .pinHold(pinHold));
